// >>> rtl/catch_edge.v
/*
  One catch input: synchronises the pin, detects the chosen edge and holds
  it as a pending capture until the next end of scan.
  Assumes pin comes from outside pclk domain; scan_end is a one-cycle pulse.
*/
`timescale 1ns/1ns
module catch_edge
(
  input  wire pclk,
  input  wire presetn,
  input  wire pin,
  input  wire falling,
  input  wire scan_end,
  output reg  flag
);
  reg sync_a;
  reg sync_b;
  reg last;
  reg pending;
  wire edge_seen;

  // Two-stage synchroniser, no filter applied to catch pins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end

  assign edge_seen = falling ? (last & ~sync_b) : (~last & sync_b);

  // Only first edge per scan is kept; flag shows it for exactly one scan
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending <= 1'b0;
      flag    <= 1'b0;
    end
    else if (scan_end)
    begin
      flag    <= pending | edge_seen;
      pending <= 1'b0;
    end
    else if (edge_seen && !pending)
      pending <= 1'b1;
  end
endmodule // catch_edge

// >>> rtl/fast_input_defines.vh
/*
  Constants of the fast-input unit: APB register offsets, field positions,
  reset values and timing counts.
  Assumes pclk at 125 MHz; included by bare name from the unit's top rtl file.
*/
`ifndef FAST_INPUT_DEFINES_VH
`define FAST_INPUT_DEFINES_VH

// Register byte offsets
`define OFS_CTRL          12'h000
`define OFS_SCAN          12'h004
`define OFS_CATCH         12'h008
`define OFS_STATUS        12'h00C
`define OFS_PRESET        12'h010
`define OFS_RESTART       12'h014
`define OFS_COUNT         12'h018
`define OFS_CMP_CLEAR     12'h01C
`define OFS_FREQ_BASE     12'h020
`define OFS_REFRESH       12'h030

// CTRL fields, one byte per input group
`define CTRL_GATE         3'h0
`define CTRL_RESET        3'h1
`define CTRL_FREQ_MODE    3'h2
`define CTRL_TWO_PHASE    3'h3
`define CTRL_KEEP         3'h4
`define CTRL_SLIM         3'h5
`define CTRL_LOAD         3'h6

// SCAN register bits: end-of-scan strobe and program load strobe
`define SCAN_END_BIT      0
`define SCAN_LOAD_BIT     1

`define CTRL_RESET_VALUE  32'h0000_0000
`define PRESET_RESET_VAL  32'hFFFF_FFFF

// Timing in their own units
`define CLK_MHZ           125
`define CALC_LONG_MS      1000
`define CALC_SHORT_MS     250
`define FAST_THRESHOLD_HZ 4000
`define CALC_LONG_CYC     (`CALC_LONG_MS * `CLK_MHZ * 1000)
`define CALC_SHORT_CYC    (`CALC_SHORT_MS * `CLK_MHZ * 1000)

`endif

// >>> rtl/fast_input_unit.v
/*
  Fast-input unit: four pulse counters with gate/reset sequencing at end of
  scan, comparison outputs, frequency measurement, and four catch inputs.
  Assumes an APB master on pclk; counter and catch pins are asynchronous;
  software writes the SCAN register once per program scan end.
*/
// Functional notes
// - Gate takes effect after that scan's end
// - Reset relay reloads counter at scan end
// - Single-phase preset hit: output on, restart zero
// - Compare clear relay turns output off
// - Two-phase preset hit restarts from restart word
// - Frequency mode counts pulses, stores result
// - Period 1 s below 4 kHz, else 250 ms
// - Error within 10 percent, 0.1 percent
// - Measure only while gate relay on
// - Program load stops frequency measurement
// - Result within one period plus scan
// - Refresh command delivers value within 250 ms
// - Frequency group never counts as counter
// - Catch holds pulses shorter than scan
// - Catch edge selectable rising or falling
// - One catch flag per input, in order
// - Catch registers 5 us pulses and longer
// - No input filter on catch inputs
// - Ordinary inputs sampled only at scan end
// - Catch flag stays on exactly one scan
// - Further catches within one scan ignored
`timescale 1ns/1ns
`include "fast_input_defines.vh"
module fast_input_unit
#(
  parameter integer CALC_LONG  = `CALC_LONG_CYC,
  parameter integer CALC_SHORT = `CALC_SHORT_CYC,
  parameter integer FAST_COUNT = `CALC_SHORT_MS * `FAST_THRESHOLD_HZ / 1000
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  count_pin,
  input  wire [3:0]  catch_pin,
  input  wire [3:0]  plain_pin,
  output reg  [3:0]  compare_out,
  output reg  [3:0]  plain_image
);
  reg  [31:0] ctrl;
  reg  [3:0]  catch_fall;
  reg  [31:0] preset      [0:3];
  reg  [31:0] restart     [0:3];
  reg  [31:0] count       [0:3];
  reg  [31:0] freq_result [0:3];
  reg  [31:0] pulse_cnt   [0:3];
  reg  [31:0] period_cnt  [0:3];
  reg  [3:0]  gate_live;
  reg  [3:0]  fast_range;
  reg  [3:0]  cnt_s1;
  reg  [3:0]  cnt_s2;
  reg  [3:0]  cnt_last;
  reg  [3:0]  plain_s1;
  reg  [3:0]  plain_s2;
  reg  [3:0]  refresh_req;
  reg  [3:0]  cmp_clear;
  wire [3:0]  catch_flag;
  wire [3:0]  cnt_rise;
  wire        wr;
  wire        scan_end;
  wire        prog_load;
  wire [3:0]  sel;
  integer     g;
  integer     h;

  // Register select codes, shared by the write and read paths
  localparam [3:0] SEL_NONE    = 4'h0;
  localparam [3:0] SEL_CTRL    = 4'h1;
  localparam [3:0] SEL_SCAN    = 4'h2;
  localparam [3:0] SEL_CATCH   = 4'h3;
  localparam [3:0] SEL_STATUS  = 4'h4;
  localparam [3:0] SEL_PRESET  = 4'h5;
  localparam [3:0] SEL_RESTART = 4'h6;
  localparam [3:0] SEL_COUNT   = 4'h7;
  localparam [3:0] SEL_CLEAR   = 4'h8;
  localparam [3:0] SEL_FREQ    = 4'h9;
  localparam [3:0] SEL_REFRESH = 4'hA;

  // Exact word offsets except the 16-byte frequency window, so a gap answers with pslverr instead of aliasing
  // onto a neighbour. Only group 0 has preset, restart and count words on
  // the bus; the other groups keep their reset preset and restart values.
  function [3:0] reg_sel;
    input [11:0] a;
    begin
      if (a == `OFS_CTRL)
        reg_sel = SEL_CTRL;
      else if (a == `OFS_SCAN)
        reg_sel = SEL_SCAN;
      else if (a == `OFS_CATCH)
        reg_sel = SEL_CATCH;
      else if (a == `OFS_STATUS)
        reg_sel = SEL_STATUS;
      else if (a == `OFS_PRESET)
        reg_sel = SEL_PRESET;
      else if (a == `OFS_RESTART)
        reg_sel = SEL_RESTART;
      else if (a == `OFS_COUNT)
        reg_sel = SEL_COUNT;
      else if (a == `OFS_CMP_CLEAR)
        reg_sel = SEL_CLEAR;
      else if ((a >> 4) == (`OFS_FREQ_BASE >> 4))
        reg_sel = SEL_FREQ;
      else if (a == `OFS_REFRESH)
        reg_sel = SEL_REFRESH;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // Decode one register group index from an address word
  function [1:0] group_of;
    input [11:0] a;
    begin
      group_of = a[3:2];
    end
  endfunction

  // Per-group ctrl bit fetch
  function ctrl_bit;
    input [31:0] c;
    input [1:0]  grp;
    input [2:0]  field;
    begin
      ctrl_bit = c[{grp, field}];
    end
  endfunction

  // Writes act only at the edge that completes the access, never twice
  assign sel       = reg_sel(paddr);
  assign wr        = psel & penable & pwrite & pready;
  assign scan_end  = wr && (sel == SEL_SCAN) && pwdata[`SCAN_END_BIT];
  assign prog_load = wr && (sel == SEL_SCAN) && pwdata[`SCAN_LOAD_BIT];
  assign cnt_rise  = cnt_s2 & ~cnt_last;

  // Catch inputs bypass any filter and latch the first edge per scan
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : catch_gen
      catch_edge u_catch
      (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin      (catch_pin[k]),
        .falling  (catch_fall[k]),
        .scan_end (scan_end),
        .flag     (catch_flag[k])
      );
    end
  endgenerate

  // Pin synchronisers for counter and ordinary inputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_s1   <= 4'h0;
      cnt_s2   <= 4'h0;
      cnt_last <= 4'h0;
      plain_s1 <= 4'h0;
      plain_s2 <= 4'h0;
    end
    else
    begin
      cnt_s1   <= count_pin;
      cnt_s2   <= cnt_s1;
      cnt_last <= cnt_s2;
      plain_s1 <= plain_pin;
      plain_s2 <= plain_s1;
    end
  end

  // Ordinary inputs form the image only at end of scan
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      plain_image <= 4'h0;
    else if (scan_end)
      plain_image <= plain_s2;
  end

  // Register writes; compare clear self-clears at scan end, refresh after one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= `CTRL_RESET_VALUE;
      catch_fall  <= 4'h0;
      cmp_clear   <= 4'h0;
      refresh_req <= 4'h0;
      for (h = 0; h < 4; h = h + 1)
      begin
        preset[h]  <= `PRESET_RESET_VAL;
        restart[h] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (scan_end)
        cmp_clear <= 4'h0;
      refresh_req <= 4'h0;
      if (wr)
      begin
        if (sel == SEL_CTRL)
          ctrl <= pwdata;
        else if (sel == SEL_CATCH)
          catch_fall <= pwdata[3:0];
        else if (sel == SEL_CLEAR)
          cmp_clear <= pwdata[3:0];
        else if (sel == SEL_REFRESH)
          refresh_req <= pwdata[3:0];
        else if (sel == SEL_PRESET)
          preset[0] <= pwdata;
        else if (sel == SEL_RESTART)
          restart[0] <= pwdata;
      end
      if (prog_load)
        ctrl <= `CTRL_RESET_VALUE;
    end
  end

  // Counters, comparison outputs and frequency measurement per group
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_live   <= 4'h0;
      fast_range  <= 4'h0;
      compare_out <= 4'h0;
      for (g = 0; g < 4; g = g + 1)
      begin
        count[g]       <= 32'h0000_0000;
        freq_result[g] <= 32'h0000_0000;
        pulse_cnt[g]   <= 32'h0000_0000;
        period_cnt[g]  <= 32'h0000_0000;
      end
    end
    else
    begin
      for (g = 0; g < 4; g = g + 1)
      begin
        // Gate and reset relays act only in end-of-scan processing
        if (scan_end)
        begin
          gate_live[g] <= ctrl_bit(ctrl, g[1:0], `CTRL_GATE);
          if (!ctrl_bit(ctrl, g[1:0], `CTRL_GATE))
          begin
            pulse_cnt[g]  <= 32'h0000_0000;
            period_cnt[g] <= 32'h0000_0000;
          end
          if (ctrl_bit(ctrl, g[1:0], `CTRL_RESET))
            count[g] <= restart[g];
          if (cmp_clear[g])
            compare_out[g] <= 1'b0;
        end
        if (prog_load)
          gate_live[g] <= 1'b0;
        if (gate_live[g] && !prog_load && !scan_end)
        begin
          if (ctrl_bit(ctrl, g[1:0], `CTRL_FREQ_MODE))
          begin
            // Frequency mode: gated pulse count over a calculation period
            if (cnt_rise[g])
              pulse_cnt[g] <= pulse_cnt[g] + 32'h1;
            period_cnt[g] <= period_cnt[g] + 32'h1;
            if (refresh_req[g] ||
                period_cnt[g] == (fast_range[g] ? CALC_SHORT - 1 : CALC_LONG - 1))
            begin
              // Scaled to Hz at period end: exact at 1 s, x4 at 250 ms; refresh stores the raw count
              if (refresh_req[g])
                freq_result[g] <= pulse_cnt[g];
              else if (fast_range[g])
                freq_result[g] <= {pulse_cnt[g][29:0], 2'b00};
              else
                freq_result[g] <= pulse_cnt[g];
              fast_range[g] <= fast_range[g] ? (pulse_cnt[g] >= FAST_COUNT)
                               : (pulse_cnt[g] >= 4 * FAST_COUNT);
              pulse_cnt[g]  <= 32'h0000_0000;
              period_cnt[g] <= 32'h0000_0000;
            end
          end
          else if (cnt_rise[g])
          begin
            // Counter mode: preset hit sets output, then a new cycle unless keep counts on
            if (count[g] + 32'h1 == preset[g])
            begin
              compare_out[g] <= 1'b1;
              if (ctrl_bit(ctrl, g[1:0], `CTRL_KEEP))
                count[g] <= count[g] + 32'h1;
              else if (ctrl_bit(ctrl, g[1:0], `CTRL_TWO_PHASE))
                count[g] <= restart[g];
              else
                count[g] <= 32'h0000_0000;
            end
            else
              count[g] <= count[g] + 32'h1;
          end
        end
      end
    end
  end

  // APB answer: zero wait, error on unmapped addresses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= 32'h0000_0000;
        if (sel == SEL_CTRL)
          prdata <= ctrl;
        else if (sel == SEL_CATCH)
          prdata <= {28'h0, catch_fall};
        else if (sel == SEL_STATUS)
          prdata <= {20'h0, plain_image, compare_out, catch_flag};
        else if (sel == SEL_PRESET)
          prdata <= preset[0];
        else if (sel == SEL_RESTART)
          prdata <= restart[0];
        else if (sel == SEL_COUNT)
          prdata <= count[0];
        else if (sel == SEL_FREQ)
          prdata <= freq_result[group_of(paddr)];
        else if (sel == SEL_NONE)
          pslverr <= 1'b1;
      end
    end
  end
endmodule // fast_input_unit

// >>> verification/fast_input_props.sv
/*
  Port checker of the fast-input unit: APB answer and refusal, compare
  outputs and plain image tied to scan strobes. Bound to the unit below.
*/
`timescale 1ns/1ns
module fast_input_props
#(
  parameter integer CALC_LONG  = 400,
  parameter integer CALC_SHORT = 100,
  parameter integer FAST_COUNT = 4
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  count_pin,
  input wire logic [3:0]  catch_pin,
  input wire logic [3:0]  plain_pin,
  input wire logic [3:0]  compare_out,
  input wire logic [3:0]  plain_image
);
  logic       acc;
  logic [1:0] scan_d;
  logic [3:0] gate_on;
  logic [3:0] freq_on;
  logic [3:0] gate_eff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completed write
  assign acc = psel && penable && pready && pwrite;

  // Shadow of gate and mode; a gate only counts after the scan end that follows it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      scan_d   <= 2'b00;
      gate_on  <= 4'h0;
      freq_on  <= 4'h0;
      gate_eff <= 4'h0;
    end
    else
    begin
      scan_d <= {scan_d[0], acc && paddr == 12'h004 && pwdata[1:0] != 2'b00};
      if (acc && paddr == 12'h000)
        for (int i = 0; i < 4; i++)
        begin
          gate_on[i] <= pwdata[8 * i];
          freq_on[i] <= pwdata[8 * i + 2];
        end
      if (acc && paddr == 12'h004 && pwdata[1])
      begin
        gate_on  <= 4'h0;
        freq_on  <= 4'h0;
        gate_eff <= 4'h0;
      end
      else if (acc && paddr == 12'h004 && pwdata[0])
        gate_eff <= gate_on;
    end

  property p_zero_wait;
    psel && !penable |=> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no answer after setup");
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("pready longer than one cycle");
  property p_err_with;
    pslverr |-> pready;
  endproperty
  a_err_with: assert property (p_err_with) else $error("pslverr without pready");
  property p_mapped;
    pready && paddr <= 12'h030 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped address refused");
  property p_unmapped;
    pready && paddr > 12'h030 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address accepted");
  property p_gate;
    (compare_out & ~$past(compare_out) & ~gate_eff) == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("compare rose without gate");
  property p_freq_no_cmp;
    (compare_out & ~$past(compare_out) & freq_on) == 4'h0;
  endproperty
  a_freq_no_cmp: assert property (p_freq_no_cmp) else $error("frequency group compared");
  property p_cmp_off;
    ($past(compare_out) & ~compare_out) != 4'h0 |-> scan_d != 2'b00;
  endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("compare fell off scan end");
  property p_image;
    $changed(plain_image) |-> scan_d != 2'b00;
  endproperty
  a_image: assert property (p_image) else $error("image moved off scan end");

  c_hit: cover property ($rose(compare_out[0]));
  c_err: cover property (pslverr);
  c_image: cover property ($changed(plain_image));
endmodule // fast_input_props

bind fast_input_unit fast_input_props #(.CALC_LONG(CALC_LONG), .CALC_SHORT(CALC_SHORT), .FAST_COUNT(FAST_COUNT)) u_props
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .count_pin, .catch_pin, .plain_pin, .compare_out, .plain_image
);

// >>> verification/sensor_model.sv
/*
  Sensors and encoder on the fast-input pins: a W-cycle pulse per request.
  Assumes requests spaced by at least one pulse plus its off time.
*/
`timescale 1ns/1ns
module sensor_model #(parameter int W = 625)
(
  input  wire logic       pclk,
  input  wire logic [3:0] count_req,
  input  wire logic [3:0] catch_req,
  input  wire logic [3:0] catch_lvl,
  input  wire logic [3:0] plain_lvl,
  output var  logic [3:0] count_pin,
  output var  logic [3:0] catch_pin,
  output var  logic [3:0] plain_pin
);
  int on_cnt [4];
  int hit_cnt [4];

  // Width held at the slim minimum, so no capture comes from a lenient pulse
  always @(posedge pclk)
    for (int i = 0; i < 4; i++)
    begin
      on_cnt[i]  <= count_req[i] ? W : (on_cnt[i] > 0 ? on_cnt[i] - 1 : 0);
      hit_cnt[i] <= catch_req[i] ? W : (hit_cnt[i] > 0 ? hit_cnt[i] - 1 : 0);
    end

  // Catch pins rest at their level and pulse to the other one
  always_comb
    for (int i = 0; i < 4; i++)
    begin
      count_pin[i] = on_cnt[i] > 0;
      catch_pin[i] = catch_lvl[i] ^ (hit_cnt[i] > 0);
      plain_pin[i] = plain_lvl[i];
    end
endmodule // sensor_model

// >>> verification/tb_top.sv
/*
  Self-checking bench of the fast-input unit over APB, with seeded random.
  Assumes sensor_model on the pins and the bound port checker.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int W = 625;
  localparam int LONG = 8000;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  count_pin;
  logic [3:0]  catch_pin;
  logic [3:0]  plain_pin;
  logic [3:0]  compare_out;
  logic [3:0]  plain_image;
  logic [3:0]  count_req;
  logic [3:0]  catch_req;
  logic [3:0]  catch_lvl;
  logic [3:0]  plain_lvl;
  logic [31:0] rd;
  logic        er;
  logic [3:0]  img;
  logic [3:0]  m;
  int          seed = 14701;
  int          n;
  int          n_fail = 0;
  int          n_compared = 0;

  // Bus clock, 8 ns
  always #4 pclk = ~pclk;

  fast_input_unit #(.CALC_LONG(LONG), .CALC_SHORT(LONG / 4), .FAST_COUNT(4)) DUT
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .count_pin, .catch_pin, .plain_pin, .compare_out, .plain_image
  );

  sensor_model #(.W(W)) u_sensors
  (
    .pclk, .count_req, .catch_req, .catch_lvl, .plain_lvl, .count_pin, .catch_pin, .plain_pin
  );

  function automatic logic [31:0] stat(input logic [3:0] fl, input logic [3:0] im);
    return {20'h0, im, 4'h0, fl};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is sampled high, then released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1)
      chk(32'h0, 32'h1, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic scan();
    xfer(1'b1, 12'h004, 32'h1);
  endtask

  task automatic rd_stat(input logic [3:0] fl, input string what);
    xfer(1'b0, 12'h00C, 32'h0);
    chk(rd, stat(fl, img), what);
  endtask

  // Ask the sensors for one pulse, then allow its off time
  task automatic pulse(input logic [3:0] c, input logic [3:0] k);
    count_req <= c;
    catch_req <= k;
    @(posedge pclk);
    count_req <= 4'h0;
    catch_req <= 4'h0;
    repeat (2 * W + 10) @(posedge pclk);
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog, well past the roughly 35k cycles the tests need
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {count_req, catch_req, catch_lvl, plain_lvl} = '0;
    img = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_stat(4'h0, "status reset");
    xfer(1'b0, 12'h010, 32'h0);
    chk(rd, 32'hFFFF_FFFF, "preset reset");
    xfer(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    $display("test reset done");
    repeat (3)
    begin
      n = $random(seed);
      plain_lvl <= n[3:0];
      repeat (4) @(posedge pclk);
      rd_stat(4'h0, "image early");
      scan();
      img = n[3:0];
      rd_stat(4'h0, "image");
    end
    $display("test plain done");
    // Wrong-way edge ignored, then two pulses on one input in one scan
    n = $random(seed);
    m = 4'h1 << n[5:4];
    xfer(1'b1, 12'h008, {28'h0, n[3:0]});
    catch_lvl <= ~n[3:0];
    scan();
    scan();
    catch_lvl <= n[3:0];
    repeat (10) @(posedge pclk);
    scan();
    rd_stat(4'h0, "wrong edge");
    pulse(4'h0, m);
    pulse(4'h0, m);
    scan();
    rd_stat(m, "catch");
    scan();
    rd_stat(4'h0, "one scan");
    $display("test catch done");
    n = $random(seed);
    n = 2 + (n & 7);
    xfer(1'b1, 12'h010, n);
    xfer(1'b1, 12'h000, 32'h2);
    scan();
    xfer(1'b1, 12'h000, 32'h1);
    pulse(4'h1, 4'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0, "gate early");
    scan();
    repeat (n - 1) pulse(4'h1, 4'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, n - 1, "count");
    chk({28'h0, compare_out}, 32'h0, "early hit");
    pulse(4'h1, 4'h0);
    chk({28'h0, compare_out}, 32'h1, "hit");
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0, "restart");
    xfer(1'b1, 12'h01C, 32'h1);
    chk({28'h0, compare_out}, 32'h1, "held");
    scan();
    repeat (2) @(posedge pclk);
    chk({28'h0, compare_out}, 32'h0, "cleared");
    pulse(4'h1, 4'h0);
    xfer(1'b1, 12'h000, 32'h3);
    scan();
    xfer(1'b1, 12'h000, 32'h1);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0, "reset relay");
    // Two-phase cycle restarts from the restart word; keep counts on to the preset
    xfer(1'b1, 12'h014, n - 1);
    xfer(1'b1, 12'h000, 32'hB);
    scan();
    xfer(1'b1, 12'h000, 32'h9);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, n - 1, "reset value");
    pulse(4'h1, 4'h0);
    chk({28'h0, compare_out}, 32'h1, "two-phase hit");
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, n - 1, "two-phase restart");
    xfer(1'b1, 12'h000, 32'h11);
    pulse(4'h1, 4'h0);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd, n, "keep");
    xfer(1'b1, 12'h01C, 32'h1);
    $display("test counter done");
    // Group one measures while group zero keeps its gate
    xfer(1'b1, 12'h000, 32'h0000_0501);
    scan();
    repeat (3) pulse(4'h2, 4'h0);
    xfer(1'b1, 12'h030, 32'h2);
    xfer(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h3, "refresh");
    chk({28'h0, compare_out}, 32'h0, "freq compare");
    // Gate toggled to restart, then one full calculation period
    xfer(1'b1, 12'h000, 32'h0000_0401);
    scan();
    xfer(1'b1, 12'h000, 32'h0000_0501);
    scan();
    repeat (2) pulse(4'h2, 4'h0);
    repeat (LONG) @(posedge pclk);
    xfer(1'b0, 12'h024, 32'h0);
    chk(rd, 32'h2, "period");
    xfer(1'b1, 12'h004, 32'h2);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "load");
    $display("test freq done");
    print_verdict();
  end
endmodule // tb_top
